// [hw/swd_cfg.svh]
// offsets, field positions, reset values and timing counts of the scan supervisor
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH
`define SWD_NBITS 8
`define SWD_AW 8
`define SWD_CLK_NS 10
`define SWD_TICK_NS 1000000
`define SWD_XCHG_CYC 3
`define SWD_NONINT_UNIT_MS 10
`define SWD_NONINT_MIN_MS 10
`define SWD_NONINT_MAX_MS 2550
`define SWD_INT_MIN_MS 1
`define SWD_INT_MAX_MS 255
`define SWD_OFF_CTRL 8'h00
`define SWD_OFF_STATUS 8'h04
`define SWD_OFF_MASK 8'h08
`define SWD_OFF_SCANMAX 8'h0C
`define SWD_OFF_SHORTWIN 8'h10
`define SWD_OFF_INTSEL 8'h14
`define SWD_OFF_LONGSEL 8'h18
`define SWD_OFF_OUTIMG 8'h1C
`define SWD_OFF_INIMG 8'h20
`define SWD_OFF_DISCACT 8'h24
`define SWD_OFF_LWIN0 8'h28
`define SWD_CTRL_RUN 0
`define SWD_CTRL_DONE 1
`define SWD_STS_WDOG 0
`define SWD_STS_DISC 1
`define SWD_STS_OCMP 2
`define SWD_STS_SCAN 3
`define SWD_STS_HALT 8
`define SWD_RST_SCANMAX 16'h0064
`define SWD_RST_SHORTWIN 16'h0101
`define SWD_RST_LWIN 16'h0FA0
`define SWD_RESP_OKAY 2'b00
`define SWD_RESP_SLVERR 2'b10
`endif

// [hw/swd_pkg.sv]
// types shared by the scan supervisor modules
`default_nettype none
package swd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_EXEC,
    ST_XCHG,
    ST_OUT,
    ST_HALT
  } swd_state_t;
endpackage
`default_nettype wire

// [hw/swd_axil.sv]
// axi4-lite register slave of the scan supervisor
`timescale 1ns/10ps
`default_nettype none
`include "swd_cfg.svh"
module swd_axil
  import swd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [`SWD_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`SWD_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_wr,
  output logic [`SWD_AW-1:0] o_waddr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_whit,
  output logic o_rd,
  output logic [`SWD_AW-1:0] o_raddr,
  input wire logic [31:0] i_rdata,
  input wire logic i_rhit
);
  ////////////////////////////////////////////////////////////////////////////
  // write side: address and data caught in either order
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `SWD_RESP_OKAY;
      o_wr <= 1'b0;
      o_waddr <= '0;
      o_wdata <= 32'h0000_0000;
      o_wstrb <= 4'h0;
    end else begin
      o_wr <= 1'b0;
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        o_waddr <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        o_wdata <= i_wdata;
        o_wstrb <= i_wstrb;
      end
      if (!o_awready && !o_wready && !o_bvalid && !o_wr) begin
        o_wr <= 1'b1;
        o_bvalid <= 1'b1;
        o_bresp <= i_whit ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side: one strobe cycle, then registered data
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rd <= 1'b0;
      o_raddr <= '0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `SWD_RESP_OKAY;
    end else begin
      o_rd <= 1'b0;
      if (o_arready && i_arvalid) begin
        o_arready <= 1'b0;
        o_raddr <= i_araddr;
        o_rd <= 1'b1;
      end
      if (o_rd) begin
        o_rvalid <= 1'b1;
        o_rdata <= i_rhit ? i_rdata : 32'h0000_0000;
        o_rresp <= i_rhit ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/swd_disc_chan.sv]
// discrepancy timer of one digital input bit
`timescale 1ns/10ps
`default_nettype none
`include "swd_cfg.svh"
module swd_disc_chan
  import swd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_eval,
  input wire logic i_mismatch,
  input wire logic i_tick,
  input wire logic [15:0] i_limit,
  output logic o_active,
  output logic o_expire
);
  logic [15:0] cnt_q;
  logic done_q;
  wire agree = i_eval && !i_mismatch;
  wire start = i_eval && i_mismatch && !o_active && !done_q;
  wire hit = o_active && i_tick && ({1'b0, cnt_q} + 17'd1 >= {1'b0, i_limit});

  // done_q keeps a persisting mismatch from re-arming after one error
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_q <= 16'h0000;
      o_active <= 1'b0;
      done_q <= 1'b0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= hit && !agree;
      if (agree) begin
        o_active <= 1'b0;
        done_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else if (start) begin
        o_active <= 1'b1;
        cnt_q <= 16'h0000;
      end else if (hit) begin
        o_active <= 1'b0;
        done_q <= 1'b1;
      end else if (o_active && i_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_timer_start: assert property (start |=> o_active && cnt_q == 16'h0000)
    else $error("timer did not start on mismatch");
  a_timer_stop: assert property (o_active && agree |=> !o_active && !o_expire)
    else $error("timer kept running after agreement");
  a_timer_count: assert property (o_active && i_tick && !hit && !agree |=>
    cnt_q == $past(cnt_q) + 16'h0001)
    else $error("timer missed a tick");
  a_expire_once: assert property (o_expire |-> done_q && !o_active ##1 !o_expire)
    else $error("expiry not a single pulse");
endmodule
`default_nettype wire

// [hw/swd_top.sv]
// scan sequencer, scan watchdog and input discrepancy checker
//
// Contract
// - sample all inputs into image at scan start
// - copy output image to outputs after execution
// - start scan watchdog at each new cycle
// - watchdog expiry halts and disables all outputs
// - compare each input bit with partner's bit
// - timer starts on mismatch, stops agree/expiry
// - short-window inputs re-checked continuously
// - expired discrepancy triggers error response
// - non-interrupt short window common, 10-2550 ms
// - interrupt short window common, 1-255 ms
// - long window set per input bit
// - long-window inputs checked once per cycle
// - exchange and compare output images first
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "swd_cfg.svh"
module swd_top
  import swd_pkg::*;
#(
  parameter int P_TICK_CYC = `SWD_TICK_NS / `SWD_CLK_NS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [`SWD_NBITS-1:0] i_digital_input_bit,
  input wire logic [`SWD_NBITS-1:0] i_partner_input_bit,
  input wire logic [`SWD_NBITS-1:0] i_partner_output_image,
  output logic [`SWD_NBITS-1:0] o_input_bit_xchg,
  output logic [`SWD_NBITS-1:0] o_output_image_xchg,
  output logic [`SWD_NBITS-1:0] o_output_module,
  output logic o_output_enable,
  output logic o_halt,
  output logic o_scan_trigger,
  output logic o_irq,
  input wire logic [`SWD_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`SWD_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  localparam int NB = `SWD_NBITS;
  localparam int XC = `SWD_XCHG_CYC;

  logic wr, rd;
  logic [`SWD_AW-1:0] waddr, raddr;
  logic [31:0] wdat, rdat;
  logic [3:0] wstrb;
  logic rhit;
  logic [NB-1:0] din_m_q, din_s_q, pdin_m_q, pdin_s_q, poimg_m_q, poimg_s_q;
  logic [16:0] tick_cnt_q;
  logic tick_q;
  logic run_q, done_q;
  logic [3:0] mask_q, sts_q, sts_set, sts_d;
  logic [15:0] scan_max_q, short_q;
  logic [NB-1:0] int_sel_q, long_sel_q, oimg_q, in_img_q, act_w, exp_w;
  logic [15:0] lwin_q [NB];
  swd_state_t st_q, st_d;
  logic [1:0] xc_cnt_q;
  logic [15:0] wd_cnt_q;

  swd_axil u_axil (
    .i_clock(i_clock), .i_rst(i_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_wr(wr), .o_waddr(waddr), .o_wdata(wdat), .o_wstrb(wstrb), .i_whit(1'b1),
    .o_rd(rd), .o_raddr(raddr), .i_rdata(rdat), .i_rhit(rhit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin and partner-link synchronisers
  always_ff @(posedge i_clock) begin
    din_m_q <= i_digital_input_bit;
    din_s_q <= din_m_q;
    pdin_m_q <= i_partner_input_bit;
    pdin_s_q <= pdin_m_q;
    poimg_m_q <= i_partner_output_image;
    poimg_s_q <= poimg_m_q;
  end

  // 1 ms tick enable
  always_ff @(posedge i_clock) begin
    if (i_rst || tick_cnt_q == 17'(P_TICK_CYC - 1)) begin
      tick_cnt_q <= 17'h0_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h0_0001;
    end
    tick_q <= !i_rst && tick_cnt_q == 17'(P_TICK_CYC - 1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  wire [31:0] wm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wm) | (wdat & wm);
  endfunction
  wire w_ctrl = wr && waddr == `SWD_OFF_CTRL;
  wire w_mask = wr && waddr == `SWD_OFF_MASK;
  wire w_smax = wr && waddr == `SWD_OFF_SCANMAX;
  wire w_swin = wr && waddr == `SWD_OFF_SHORTWIN;
  wire w_isel = wr && waddr == `SWD_OFF_INTSEL;
  wire w_lsel = wr && waddr == `SWD_OFF_LONGSEL;
  wire w_oimg = wr && waddr == `SWD_OFF_OUTIMG;
  // spelled out: a function call here would not follow changes of wdat
  wire [31:0] ctrl_nv = (32'(run_q) & ~wm) | (wdat & wm);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      run_q <= 1'b0;
      done_q <= 1'b0;
      mask_q <= 4'h0;
      scan_max_q <= `SWD_RST_SCANMAX;
      short_q <= `SWD_RST_SHORTWIN;
      int_sel_q <= '0;
      long_sel_q <= '0;
      oimg_q <= '0;
    end else begin
      done_q <= w_ctrl && wdat[`SWD_CTRL_DONE] && wstrb[0];
      if (w_ctrl) run_q <= ctrl_nv[`SWD_CTRL_RUN];
      if (w_mask) mask_q <= 4'(merge(32'(mask_q)));
      if (w_smax) scan_max_q <= 16'(merge(32'(scan_max_q)));
      if (w_swin) short_q <= 16'(merge(32'(short_q)));
      if (w_isel) int_sel_q <= NB'(merge(32'(int_sel_q)));
      if (w_lsel) long_sel_q <= NB'(merge(32'(long_sel_q)));
      if (w_oimg) oimg_q <= NB'(merge(32'(oimg_q)));
    end
  end

  // short windows: one common value per input class, zero treated as minimum
  wire [7:0] swin_ni = (short_q[7:0] == 8'h00) ? 8'h01 : short_q[7:0];
  wire [7:0] swin_in = (short_q[15:8] == 8'h00) ? 8'h01 : short_q[15:8];
  wire [15:0] lim_ni = 16'(swin_ni * `SWD_NONINT_UNIT_MS);
  wire [15:0] lim_in = {8'h00, swin_in};

  ////////////////////////////////////////////////////////////////////////////
  // per-bit long windows and discrepancy timers
  wire scan_q = o_scan_trigger;
  generate
    for (genvar i = 0; i < NB; i++) begin : g_bit
      localparam logic [`SWD_AW-1:0] A = `SWD_AW'(`SWD_OFF_LWIN0 + 4 * i);
      wire w_lw = wr && waddr == A;
      wire [15:0] lim = long_sel_q[i] ? lwin_q[i] : (int_sel_q[i] ? lim_in : lim_ni);
      wire mism = din_s_q[i] ^ pdin_s_q[i];
      // long bits only look at the link at scan start, short bits every cycle
      wire eval = long_sel_q[i] ? scan_q : 1'b1;
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          lwin_q[i] <= `SWD_RST_LWIN;
        end else if (w_lw) begin
          lwin_q[i] <= 16'(merge(32'(lwin_q[i])));
        end
      end
      swd_disc_chan u_chan (
        .i_clock(i_clock), .i_rst(i_rst), .i_eval(eval), .i_mismatch(mism),
        .i_tick(tick_q), .i_limit(lim), .o_active(act_w[i]), .o_expire(exp_w[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer and watchdog
  wire wd_run = st_q == ST_EXEC || st_q == ST_XCHG || st_q == ST_OUT;
  wire wd_exp = wd_run && tick_q && ({1'b0, wd_cnt_q} + 17'd1 >= {1'b0, scan_max_q});
  wire xc_end = st_q == ST_XCHG && xc_cnt_q == 2'(XC - 1);
  wire xc_bad = xc_end && oimg_q != poimg_s_q;
  wire disc_exp = |exp_w;
  wire fault = wd_exp || disc_exp || xc_bad;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (run_q) st_d = ST_SAMPLE;
      ST_SAMPLE: st_d = ST_EXEC;
      ST_EXEC: if (done_q) st_d = ST_XCHG;
      ST_XCHG: if (xc_end) st_d = ST_OUT;
      ST_OUT: st_d = run_q ? ST_SAMPLE : ST_IDLE;
      ST_HALT: st_d = ST_HALT;
      default: st_d = ST_HALT;
    endcase
    if (fault) st_d = ST_HALT;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      xc_cnt_q <= 2'b00;
      wd_cnt_q <= 16'h0000;
      in_img_q <= '0;
      o_scan_trigger <= 1'b0;
      o_output_module <= '0;
      o_output_enable <= 1'b0;
      o_halt <= 1'b0;
    end else begin
      st_q <= st_d;
      xc_cnt_q <= (st_q == ST_XCHG) ? xc_cnt_q + 2'b01 : 2'b00;
      o_scan_trigger <= st_q == ST_SAMPLE && !fault;
      if (st_q == ST_SAMPLE) begin
        in_img_q <= din_s_q;
        wd_cnt_q <= 16'h0000;
      end else if (wd_run && tick_q) begin
        wd_cnt_q <= wd_cnt_q + 16'h0001;
      end
      o_halt <= st_d == ST_HALT;
      if (st_d == ST_HALT) begin
        o_output_module <= '0;
        o_output_enable <= 1'b0;
      end else if (st_q == ST_OUT) begin
        o_output_module <= oimg_q;
        o_output_enable <= 1'b1;
      end
    end
  end

  // both images go to the partner; inputs as synced, outputs as written
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_input_bit_xchg <= '0;
      o_output_image_xchg <= '0;
    end else begin
      o_input_bit_xchg <= din_s_q;
      o_output_image_xchg <= oimg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, interrupt, read mux
  wire rd_sts = rd && raddr == `SWD_OFF_STATUS;
  assign sts_set = {st_q == ST_SAMPLE, xc_bad, disc_exp, wd_exp};
  // a new event in the read-clear cycle survives the clear
  assign sts_d = (rd_sts ? 4'h0 : sts_q) | sts_set;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sts_q <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      sts_q <= sts_d;
      o_irq <= |(sts_d & mask_q);
    end
  end

  wire [`SWD_AW-1:0] lw_off = raddr - `SWD_OFF_LWIN0;
  wire rd_lw = raddr >= `SWD_OFF_LWIN0 && lw_off < `SWD_AW'(4 * NB) && raddr[1:0] == 2'b00;
  wire [2:0] lw_idx = lw_off[4:2];
  wire [31:0] sts_rd = 32'({o_halt, 4'h0, sts_q});
  assign rdat = raddr == `SWD_OFF_CTRL ? 32'(run_q) :
    raddr == `SWD_OFF_STATUS ? sts_rd :
    raddr == `SWD_OFF_MASK ? 32'(mask_q) :
    raddr == `SWD_OFF_SCANMAX ? 32'(scan_max_q) :
    raddr == `SWD_OFF_SHORTWIN ? 32'(short_q) :
    raddr == `SWD_OFF_INTSEL ? 32'(int_sel_q) :
    raddr == `SWD_OFF_LONGSEL ? 32'(long_sel_q) :
    raddr == `SWD_OFF_OUTIMG ? 32'(oimg_q) :
    raddr == `SWD_OFF_INIMG ? 32'(in_img_q) :
    raddr == `SWD_OFF_DISCACT ? 32'(act_w) :
    rd_lw ? 32'(lwin_q[lw_idx]) : 32'h0000_0000;
  assign rhit = rd_lw || (raddr <= `SWD_OFF_DISCACT && raddr[1:0] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_xchg_end;
    st_q == ST_XCHG && xc_cnt_q == 2'(XC - 1);
  endsequence
  sequence s_cycle_start;
    st_q == ST_SAMPLE && !fault ##1 o_scan_trigger;
  endsequence
  a_image_sample: assert property (s_cycle_start |-> in_img_q == $past(din_s_q))
    else $error("input image not taken at scan start");
  a_output_copy: assert property (st_q == ST_OUT && !fault |=>
    o_output_module == $past(oimg_q) && o_output_enable)
    else $error("output image not copied");
  a_wdog_reload: assert property (o_scan_trigger |-> wd_cnt_q == 16'h0000)
    else $error("watchdog not reloaded by scan trigger");
  a_wdog_halt: assert property (wd_exp |=> o_halt && !o_output_enable ##1 o_halt)
    else $error("watchdog expiry did not halt");
  a_halt_outputs: assert property (o_halt |-> !o_output_enable && o_output_module == '0)
    else $error("outputs live while halted");
  a_compare_halt: assert property (s_xchg_end ##0 oimg_q != poimg_s_q |=>
    o_halt && sts_q[`SWD_STS_OCMP])
    else $error("output image mismatch not caught");
  a_disc_error: assert property (disc_exp |=> o_halt && sts_q[`SWD_STS_DISC])
    else $error("discrepancy expiry without error");
  a_long_eval: assert property (|(act_w & ~$past(act_w) & long_sel_q) |-> $past(scan_q))
    else $error("long-window bit checked outside scan start");
  a_short_range: assert property (lim_ni >= 16'(`SWD_NONINT_MIN_MS) &&
    lim_ni <= 16'(`SWD_NONINT_MAX_MS) && lim_in >= 16'(`SWD_INT_MIN_MS) &&
    lim_in <= 16'(`SWD_INT_MAX_MS))
    else $error("short window out of range");
  a_tick_pulse: assert property (tick_q |=> !tick_q)
    else $error("tick longer than one cycle");
endmodule
`default_nettype wire

// [tb/swd_partner_model.sv]
// model of the redundant partner subunit across the parallel link
`timescale 1ns/10ps
`default_nettype none
`include "swd_cfg.svh"
module swd_partner_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic [`SWD_NBITS-1:0] i_pins,
  input wire logic [`SWD_NBITS-1:0] i_image,
  input wire logic [`SWD_NBITS-1:0] i_peer_image,
  output logic [`SWD_NBITS-1:0] o_input_bit,
  output logic [`SWD_NBITS-1:0] o_output_image,
  output logic o_image_mismatch
);
  logic [`SWD_NBITS-1:0] pins_q;
  logic [`SWD_NBITS-1:0] image_q;
  ////////////////////////////////////////////////////////////////////////////////
  // slow mode adds one stage, still well inside the exchange window
  always_ff @(posedge i_clock) begin
    pins_q <= i_pins;
    image_q <= i_image;
    o_input_bit <= i_slow ? pins_q : i_pins;
    o_output_image <= i_slow ? image_q : i_image;
    o_image_mismatch <= (i_peer_image != i_image);
  end
endmodule
`default_nettype wire

// [tb/tb_scan_watchdog_discrepancy_check.sv]
// self-checking bench of the scan supervisor
`timescale 1ns/10ps
`default_nettype none
`include "swd_cfg.svh"
module tb_scan_watchdog_discrepancy_check;
  localparam int P = 10;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic slow = 1'b1;
  logic [7:0] pins = 8'h00;
  logic [7:0] ppins = 8'h00;
  logic [7:0] pimg = 8'h00;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] in_x, out_x, outm, p_in, p_img;
  logic en, halt, trig, irq, pmis, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire [2:0] flg = {halt, en, trig};
  int fails = 0;
  int checked = 0;
  always #5 i_clock = ~i_clock;
  swd_top #(.P_TICK_CYC(P)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_digital_input_bit(pins),
    .i_partner_input_bit(p_in), .i_partner_output_image(p_img),
    .o_input_bit_xchg(in_x), .o_output_image_xchg(out_x), .o_output_module(outm),
    .o_output_enable(en), .o_halt(halt), .o_scan_trigger(trig), .o_irq(irq),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  swd_partner_model u_partner (
    .i_clock(i_clock), .i_slow(slow), .i_pins(ppins), .i_image(pimg),
    .i_peer_image(out_x), .o_input_bit(p_in), .o_output_image(p_img),
    .o_image_mismatch(pmis));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // every polling loop goes through here so a hang ends the run
  task automatic step(inout int n, input int lim);
    @(posedge i_clock);
    n++;
    if (n > lim) begin
      chk("wait bound", lim, n);
      summarize();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step(n, 50);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ta = ta | awready;
      tw = tw | wready;
    end while (!(ta && tw));
    do step(n, 50); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, `SWD_RESP_OKAY}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n, 50); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n, 50); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk($sformatf("rdata at %h", a), e, rdata);
    chk($sformatf("rresp at %h", a), {30'h0, r}, {30'h0, rresp});
  endtask
  task automatic wait_flag(input int k, input int lim, output int n);
    n = 0;
    do step(n, lim); while (flg[k] !== 1'b1);
  endtask
  task automatic halt_in(input int lo, input int hi);
    int n;
    wait_flag(2, hi, n);
    chk("halt delay not early", 32'h0000_0001, {31'h0, n >= lo});
  endtask
  task automatic do_rst();
    @(posedge i_clock);
    i_rst <= 1'b1;
    slow <= 1'b0;
    pins <= 8'h00;
    ppins <= 8'h00;
    pimg <= 8'h00;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_regs();
    axi_rd(`SWD_OFF_SCANMAX, {16'h0, `SWD_RST_SCANMAX}, `SWD_RESP_OKAY);
    axi_rd(`SWD_OFF_SHORTWIN, {16'h0, `SWD_RST_SHORTWIN}, `SWD_RESP_OKAY);
    axi_rd(`SWD_OFF_LWIN0, {16'h0, `SWD_RST_LWIN}, `SWD_RESP_OKAY);
    axi_rd(8'hFC, 32'h0000_0000, `SWD_RESP_SLVERR);
    axi_wr(`SWD_OFF_INIMG, 32'h0000_00FF);
    axi_rd(`SWD_OFF_INIMG, 32'h0000_0000, `SWD_RESP_OKAY);
  endtask
  task automatic sc_scan();
    int n;
    pins <= 8'h5A;
    ppins <= 8'h5A;
    pimg <= 8'hC3;
    axi_wr(`SWD_OFF_OUTIMG, 32'h0000_00C3);
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0001);
    wait_flag(0, 20, n);
    chk("irq while masked", 32'h0000_0000, {31'h0, irq});
    axi_rd(`SWD_OFF_INIMG, 32'h0000_005A, `SWD_RESP_OKAY);
    chk("input exchange", 32'h0000_005A, {24'h0, in_x});
    chk("output image exchange", 32'h0000_00C3, {24'h0, out_x});
    axi_wr(`SWD_OFF_MASK, 32'h0000_0008);
    repeat (2) @(posedge i_clock);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    axi_rd(`SWD_OFF_STATUS, 32'h0000_0008, `SWD_RESP_OKAY);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0003);
    wait_flag(1, 20, n);
    chk("output module", 32'h0000_00C3, {24'h0, outm});
    chk("partner image compare", 32'h0000_0000, {31'h0, pmis});
    wait_flag(0, 20, n);
    pimg <= 8'h00;
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0003);
    halt_in(1, 20);
    chk("outputs in halt", 32'h0000_0000, {23'h0, outm, en});
    axi_rd(`SWD_OFF_STATUS, 32'h0000_010C, `SWD_RESP_OKAY);
  endtask
  task automatic sc_wdog();
    int n;
    do_rst();
    axi_wr(`SWD_OFF_SCANMAX, 32'h0000_0005);
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0001);
    wait_flag(0, 20, n);
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0003);
    wait_flag(1, 20, n);
    wait_flag(0, 20, n);
    chk("halt after retrigger", 32'h0000_0000, {31'h0, halt});
    halt_in(4 * P - 2, 5 * P + 3);
    chk("outputs in halt", 32'h0000_0000, {23'h0, outm, en});
    axi_rd(`SWD_OFF_STATUS, 32'h0000_0109, `SWD_RESP_OKAY);
  endtask
  task automatic sc_disc(input logic [7:0] sel, input logic [7:0] m, input int lo,
                         input int hi, input logic agree);
    do_rst();
    axi_wr(`SWD_OFF_SCANMAX, 32'h0000_03E8);
    axi_wr(`SWD_OFF_INTSEL, {24'h0, sel});
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0001);
    ppins <= m;
    if (agree) begin
      repeat (lo / 2) @(posedge i_clock);
      axi_rd(`SWD_OFF_DISCACT, {24'h0, m}, `SWD_RESP_OKAY);
      ppins <= 8'h00;
      repeat (2 * hi) @(posedge i_clock);
      chk("halt after agreement", 32'h0000_0000, {31'h0, halt});
      axi_rd(`SWD_OFF_DISCACT, 32'h0000_0000, `SWD_RESP_OKAY);
      ppins <= m;
    end
    halt_in(lo, hi);
    axi_rd(`SWD_OFF_STATUS, 32'h0000_010A, `SWD_RESP_OKAY);
  endtask
  // mismatch arrives after the compare point, so only the next cycle sees it
  task automatic sc_long();
    int n;
    do_rst();
    axi_wr(`SWD_OFF_SCANMAX, 32'h0000_03E8);
    axi_wr(`SWD_OFF_LONGSEL, 32'h0000_0001);
    axi_wr(`SWD_OFF_LWIN0, 32'h0000_0003);
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0001);
    wait_flag(0, 20, n);
    ppins <= 8'h01;
    repeat (6 * P) @(posedge i_clock);
    chk("halt before compare", 32'h0000_0000, {31'h0, halt});
    axi_wr(`SWD_OFF_CTRL, 32'h0000_0003);
    halt_in(2 * P, 4 * P + 20);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    sc_regs();
    sc_scan();
    sc_wdog();
    sc_disc(8'h00, 8'h04, 9 * P, 10 * P + 8, 1'b1);
    sc_disc(8'h08, 8'h08, 1, P + 8, 1'b0);
    sc_long();
    summarize();
  end
endmodule
`default_nettype wire
